// *** adc_sample_output_port_tb.sv ***
// Self-checking bench for the converter sample output port
`default_nettype none
module adc_sample_output_port_tb;
   import asop_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic [SAMPLE_WIDTH-1:0] sampleIn = '0, sampleWordBits, sampleWordOe, capWord;
   logic                    clk_sys = 1'b0, resetn = 1'b0, sampleSigned = 1'b0;
   logic                    sampleValid = 1'b0, outEnableN = 1'b1, powerDown = 1'b1;
   logic                    sampleReady, lowPower, wordValid, capStrobe, dropMode = 1'b0;
   int                      err_count = 0, total_checks = 0, cyc = 0, drops = 0, acc, i, lat;
   logic [SAMPLE_WIDTH-1:0] expW[$];
   int                      expC[$];
   always #2 clk_sys = ~clk_sys; // 250 MHz device clock stand
   asop_port dut (.clk_sys(clk_sys), .resetn(resetn), .sampleIn(sampleIn),
      .sampleSigned(sampleSigned), .sampleValid(sampleValid), .sampleReady(sampleReady),
      .outEnableN(outEnableN), .powerDown(powerDown), .sampleWordBits(sampleWordBits),
      .sampleWordOe(sampleWordOe), .lowPower(lowPower), .wordValid(wordValid));
   asop_capture cap (.clk_sys(clk_sys), .busIn(sampleWordBits), .busOe(sampleWordOe),
      .wordValid(wordValid), .capWord(capWord), .capStrobe(capStrobe));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [SAMPLE_WIDTH-1:0] exp, got);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_sim;
      $display("Checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Called at a falling edge; holds the offer until the buffer has room
   task automatic send(input logic [SAMPLE_WIDTH-1:0] v, input logic sg);
      int n;
      n = 0;
      sampleIn = v;
      sampleSigned = sg;
      sampleValid = 1'b1;
      while (sampleReady !== 1'b1 && n < 100)
      begin
         @(negedge clk_sys);
         n++;
      end
      expW.push_back(sg ? v ^ SIGNED_OFFSET : v);
      expC.push_back(cyc + 1);
      @(negedge clk_sys);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc > 2000)
      begin
         err_count++;
         end_sim();
      end
   end
   // Words lost during wake-up are skipped only in drop mode
   always @(negedge clk_sys)
   begin
      if (capStrobe === 1'b1)
      begin
         while (dropMode && expW.size() > 1 && expW[0] !== capWord)
         begin
            void'(expW.pop_front());
            void'(expC.pop_front());
            drops++;
         end
         if (expW.size() == 0)
         begin
            total_checks++;
            err_count++;
            $display("Error extra word expected none seen %h", capWord);
         end
         else
         begin
            check("word", expW.pop_front(), capWord);
            lat = expC.pop_front();
            if (!dropMode)
               check("latency", 12'(PIPE_LATENCY), 12'(cyc - lat));
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(41));
      repeat (5) @(posedge clk_sys);
      check("oe in reset", '0, sampleWordOe);
      check("lowPower in reset", 12'(1), 12'(lowPower));
      @(negedge clk_sys);
      resetn = 1'b1;
      powerDown = 1'b0;
      outEnableN = 1'b0;
      repeat (14) @(negedge clk_sys);
      check("lowPower active", '0, 12'(lowPower));
      check("oe driving", SAMPLE_FULL, sampleWordOe);
      send(SAMPLE_RESET, 1'b0);
      send(SAMPLE_FULL, 1'b0);
      send(SIGNED_OFFSET, 1'b1);
      for (i = 0; i < SAMPLE_WIDTH; i++)
         send(12'h001 << i, 1'b0);
      for (i = 0; i < 24; i++)
         send(12'($urandom()), 1'($urandom()));
      sampleValid = 1'b0;
      repeat (12) @(negedge clk_sys);
      check("stream drained", '0, 12'(expW.size()));
      outEnableN = 1'b1;
      repeat (4) @(negedge clk_sys);
      check("oe released", '0, sampleWordOe);
      outEnableN = 1'b0;
      repeat (4) @(negedge clk_sys);
      check("oe restored", SAMPLE_FULL, sampleWordOe);
      // Buffer fills while powered down; nothing may leave
      powerDown = 1'b1;
      sampleSigned = 1'b0;
      repeat (4) @(negedge clk_sys);
      check("lowPower down", 12'(1), 12'(lowPower));
      acc = 0;
      dropMode = 1'b1;
      for (i = 0; i < 40; i++)
      begin
         sampleIn = 12'($urandom());
         sampleValid = 1'b1;
         if (sampleReady === 1'b1)
         begin
            expW.push_back(sampleIn);
            expC.push_back(0);
            acc++;
         end
         @(negedge clk_sys);
      end
      sampleValid = 1'b0;
      check("fill count", 12'(FIFO_DEPTH), 12'(acc));
      check("ready when full", '0, 12'(sampleReady));
      check("valid in power-down", '0, 12'(wordValid));
      powerDown = 1'b0;
      repeat (60) @(negedge clk_sys);
      check("drained", '0, 12'(expW.size()));
      check("wake drops", 12'(PIPE_LATENCY), 12'(drops));
      end_sim();
   end
endmodule
`default_nettype wire

// *** asop_capture.sv ***
// Capture logic model that latches words from the converter output bus
`default_nettype none
module asop_capture
   import asop_pkg::*;
(
   input  wire logic                              clk_sys,
   input  wire logic [asop_pkg::SAMPLE_WIDTH-1:0] busIn,
   input  wire logic [asop_pkg::SAMPLE_WIDTH-1:0] busOe,
   input  wire logic                              wordValid,
   output logic      [asop_pkg::SAMPLE_WIDTH-1:0] capWord,
   output logic                                   capStrobe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [SAMPLE_WIDTH-1:0] lastWord_reg;
   // Released lines toggle so a floating bus never looks like data
   always_comb
   begin
      for (int i = 0; i < SAMPLE_WIDTH; i++)
      begin
         capWord[i] = busOe[i] ? busIn[i] : ~lastWord_reg[i];
      end
   end
   always_ff @(posedge clk_sys)
   begin
      lastWord_reg <= capWord;
   end
   // Words outside the valid window are not trusted
   assign capStrobe = wordValid && (&busOe);
endmodule
`default_nettype wire

// *** asop_fifo.sv ***
// Synchronous FIFO with valid and ready on both sides
`default_nettype none
module asop_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 32,
   parameter int AW    = 5
)(
   input  wire logic             clk_sys,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic [WIDTH-1:0]      outData,
   output logic                  outValid,
   input  wire logic             outReady
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wrPtr_reg;
   logic [AW:0]      rdPtr_reg;
   logic [AW:0]      wrPtr_next;
   logic [AW:0]      rdPtr_next;
   logic             push;
   logic             pop;

   assign outValid   = (wrPtr_reg != rdPtr_reg);
   assign push       = inValid && inReady;
   assign pop        = outValid && outReady;
   assign outData    = mem[rdPtr_reg[AW-1:0]];
   assign wrPtr_next = push ? (wrPtr_reg + 1'b1) : wrPtr_reg;
   assign rdPtr_next = pop ? (rdPtr_reg + 1'b1) : rdPtr_reg;

   always_ff @(posedge clk_sys)
   begin
      if (push)
      begin
         mem[wrPtr_reg[AW-1:0]] <= inData;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         inReady   <= 1'b1;
      end
      else
      begin
         wrPtr_reg <= wrPtr_next;
         rdPtr_reg <= rdPtr_next;
         // Registered so the ready port comes straight from a flop
         inReady   <= !((wrPtr_next[AW] != rdPtr_next[AW]) &&
                        (wrPtr_next[AW-1:0] == rdPtr_next[AW-1:0]));
      end
   end

   overflow_guard_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      inReady == ((wrPtr_reg - rdPtr_reg) != (AW+1)'(DEPTH)))
      else $error("ready flag disagrees with fill level");
endmodule
`default_nettype wire

// *** asop_pkg.sv ***
// Package of constants for the converter sample output port
// What this block does
// - Each result is a 12-bit offset-binary word, zero scale all zeros.
// - A sample's word reaches the bus six clocks later, one per clock.
// - A sample is taken on every rising clock edge with a word buffered, except in power-down.
// - Bus driven while output enable is low, released while it is high.
// - Power-down high gives low-power mode; low gives normal conversion.
// - Result bit zero is output bit zero, bit eleven is output bit eleven.
`default_nettype none
package asop_pkg;
   localparam int          SAMPLE_WIDTH   = 12;
   localparam int          PIPE_LATENCY   = 6;
   localparam int          FIFO_DEPTH     = 32;
   localparam int          FIFO_AW        = 5;
   localparam logic [11:0] SAMPLE_RESET   = 12'h000;
   localparam logic [11:0] SAMPLE_FULL    = 12'hfff;
   localparam logic [11:0] SIGNED_OFFSET  = 12'h800;
   typedef enum logic [1:0] {ST_ACTIVE, ST_DOWN, ST_WAKE} asop_mode_t;
endpackage
`default_nettype wire

// *** asop_port.sv ***
// Digital output port of a pipelined sampling converter
`default_nettype none
module asop_port
   import asop_pkg::*;
(
   input  wire logic                          clk_sys,
   input  wire logic                          resetn,
   input  wire logic [asop_pkg::SAMPLE_WIDTH-1:0] sampleIn,
   input  wire logic                          sampleSigned,
   input  wire logic                          sampleValid,
   output logic                               sampleReady,
   input  wire logic                          outEnableN,
   input  wire logic                          powerDown,
   output logic [asop_pkg::SAMPLE_WIDTH-1:0]  sampleWordBits,
   output logic [asop_pkg::SAMPLE_WIDTH-1:0]  sampleWordOe,
   output logic                               lowPower,
   output logic                               wordValid
);
   import asop_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [1:0] oeSync_reg;
   logic [1:0] pdSync_reg;
   logic       oeN;
   logic       pd;

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         oeSync_reg <= 2'h3;
         pdSync_reg <= 2'h3;
      end
      else
      begin
         oeSync_reg <= {oeSync_reg[0], outEnableN};
         pdSync_reg <= {pdSync_reg[0], powerDown};
      end
   end
   assign oeN = oeSync_reg[1];
   assign pd  = pdSync_reg[1];

   ////////////////////////////////////////////////////////////////////////
   // Mode control
   asop_mode_t mode_reg;
   asop_mode_t mode_next;
   logic [2:0] wakeCnt_reg;

   always_comb
   begin
      mode_next = mode_reg;
      case (mode_reg)
         ST_ACTIVE: if (pd) mode_next = ST_DOWN;
         ST_DOWN:   if (!pd) mode_next = ST_WAKE;
         ST_WAKE:
         begin
            if (pd)
               mode_next = ST_DOWN;
            else if (wakeCnt_reg == 3'(PIPE_LATENCY - 1))
               mode_next = ST_ACTIVE;
         end
         default:   mode_next = ST_DOWN;
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         mode_reg <= ST_DOWN;
      else
         mode_reg <= mode_next;
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         wakeCnt_reg <= 3'h0;
      else if (mode_reg == ST_WAKE)
         wakeCnt_reg <= wakeCnt_reg + 3'h1;
      else
         wakeCnt_reg <= 3'h0;
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         lowPower <= 1'b1;
      else
         lowPower <= (mode_next == ST_DOWN);
   end

   ////////////////////////////////////////////////////////////////////////
   // Sample buffer; the converter drains it one word per clock
   logic [SAMPLE_WIDTH-1:0] fifoData;
   logic                    fifoValid;
   logic                    take;
   logic [SAMPLE_WIDTH-1:0] coded;

   // Signed input is shifted into offset binary by flipping the sign bit
   assign coded = sampleSigned ? (sampleIn ^ SIGNED_OFFSET) : sampleIn;

   asop_fifo #(
      .WIDTH (SAMPLE_WIDTH),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo (
      .clk_sys  (clk_sys),
      .resetn   (resetn),
      .inData   (coded),
      .inValid  (sampleValid),
      .inReady  (sampleReady),
      .outData  (fifoData),
      .outValid (fifoValid),
      .outReady (take)
   );

   // Converter is stalled in power-down, so the buffer fills and pushes back
   assign take = (mode_reg != ST_DOWN);

   ////////////////////////////////////////////////////////////////////////
   // Pipeline: one sample per edge, six stages to the pins
   logic [SAMPLE_WIDTH-1:0] pipe_reg [PIPE_LATENCY];
   logic [PIPE_LATENCY-1:0] pipeValid_reg;

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         pipeValid_reg <= '0;
      else
         pipeValid_reg <= {pipeValid_reg[PIPE_LATENCY-2:0],
                           take && fifoValid && (mode_reg == ST_ACTIVE)};
   end

   genvar s;
   generate
      for (s = 0; s < PIPE_LATENCY; s++)
      begin : g_stage
         if (s == 0)
         begin : g_first
            always_ff @(posedge clk_sys or negedge resetn)
            begin
               if (!resetn)
                  pipe_reg[s] <= SAMPLE_RESET;
               else
                  pipe_reg[s] <= (take && fifoValid) ? fifoData : SAMPLE_RESET;
            end
         end
         else
         begin : g_next
            always_ff @(posedge clk_sys or negedge resetn)
            begin
               if (!resetn)
                  pipe_reg[s] <= SAMPLE_RESET;
               else
                  pipe_reg[s] <= pipe_reg[s-1];
            end
         end
      end
   endgenerate

   // Stage five is the output register; the bus carries it one-to-one
   assign sampleWordBits = pipe_reg[PIPE_LATENCY-1];

   ////////////////////////////////////////////////////////////////////////
   // Output drivers and validity
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         sampleWordOe <= '0;
      else
         sampleWordOe <= {SAMPLE_WIDTH{!oeN}};
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         wordValid <= 1'b0;
      else
         // Words still in flight across a power-down stay flagged invalid
         wordValid <= pipeValid_reg[PIPE_LATENCY-2] && !pd && (mode_reg == ST_ACTIVE);
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence taken_s;
      take && fifoValid;
   endsequence

   // Pin held low through the whole wake window
   sequence woken_s;
      ((mode_reg == ST_DOWN) && !pd) ##1 (!pd) [*6];
   endsequence

   latency_six_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      taken_s |-> ##6 (sampleWordBits == $past(fifoData, 6)))
      else $error("word not on bus six clocks after sample");

   oe_drive_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      oeN |=> (sampleWordOe == '0))
      else $error("bus driven while output enable high");

   oe_enable_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      !oeN |=> (sampleWordOe == SAMPLE_FULL))
      else $error("bus not driven while output enable low");

   pd_lowpower_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      pd && (mode_reg != ST_WAKE) |=> lowPower)
      else $error("low power not entered");

   wake_active_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      woken_s |=> (mode_reg == ST_ACTIVE))
      else $error("active mode not resumed after power-down");

   down_stall_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (mode_reg == ST_DOWN) && fifoValid |=> fifoValid && (pipe_reg[0] == SAMPLE_RESET))
      else $error("sample taken in power-down");

   bit_order_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      taken_s |-> ##6 ((sampleWordBits[0] == $past(fifoData[0], 6)) &&
                       (sampleWordBits[SAMPLE_WIDTH-1] == $past(fifoData[SAMPLE_WIDTH-1], 6))))
      else $error("output bit order wrong");

   valid_pd_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      $rose(mode_reg == ST_WAKE) |-> (!wordValid) [*6])
      else $error("word flagged valid during wake latency");
endmodule
`default_nettype wire
